// [src/core_flags.v]
// Flag, power control and program counter registers of the core.
// Assumes one clock per instruction cycle and separate reset cause pulses.
`timescale 1ns/1ns
`include "core_flags_regs.vh"
module core_flags (
  // Clock and reset
  input wire CLK_I,
  input wire RST_B_I,
  // Reset causes
  input wire POR_PULSE_I,
  input wire BOR_PULSE_I,
  input wire [1:0] BOR_CFG_I,
  // Events
  input wire OSC_FAIL_I,
  input wire CMP_A_I,
  input wire CMP_B_I,
  input wire NV_DONE_I,
  // Register port
  input wire [`ADDR_W-1:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [7:0] RDATA_O,
  // Program flow
  input wire ADVANCE_I,
  input wire JUMP_I,
  input wire [`GOTO_W-1:0] TARGET_I,
  output wire [`PC_W-1:0] PC_O,
  // Control outputs
  output wire WAKE_EN_O,
  output wire BOR_EN_O,
  output wire IRQ_O
);
  reg [7:0] flags;
  reg [7:0] mask;
  reg wake_en;
  reg sbor_en;
  reg por_stat;
  reg bor_stat;
  reg [`LATCH_W-1:0] latch;
  reg [7:0] next_flags;
  wire osc_lvl;
  wire nv_lvl;
  wire cmp_a_chg;
  wire cmp_b_chg;
  wire osc_chg;
  wire nv_chg;
  wire wr_flags = WR_I && (ADDR_I == `ADDR_FLAGS2);
  wire wr_pwr = WR_I && (ADDR_I == `ADDR_PWRCTL);
  wire wr_low = WR_I && (ADDR_I == `ADDR_PCLOW);
  wire [7:0] pwr_view;

  edge_event u_cmp_a (.clk_i(CLK_I), .rst_b_i(RST_B_I), .async_i(CMP_A_I),
    .level_o(), .change_o(cmp_a_chg));
  edge_event u_cmp_b (.clk_i(CLK_I), .rst_b_i(RST_B_I), .async_i(CMP_B_I),
    .level_o(), .change_o(cmp_b_chg));
  edge_event u_osc (.clk_i(CLK_I), .rst_b_i(RST_B_I), .async_i(OSC_FAIL_I),
    .level_o(osc_lvl), .change_o(osc_chg));
  edge_event u_nv (.clk_i(CLK_I), .rst_b_i(RST_B_I), .async_i(NV_DONE_I),
    .level_o(nv_lvl), .change_o(nv_chg));

  pc_unit #(.PC_W(`PC_W)) u_pc (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .advance_i(ADVANCE_I),
    .low_write_i(wr_low),
    .low_data_i(WDATA_I),
    .jump_i(JUMP_I),
    .target_i(TARGET_I),
    .latch_i(latch),
    .pc_o(PC_O)
  );

  // Flag update, set beats clear
  always @* begin
    next_flags = flags;
    if (wr_flags) begin
      next_flags = WDATA_I & `FLAGS2_IMPL;
    end
    if (osc_chg && !osc_lvl) begin
      next_flags[`BIT_OSC_FAIL] = 1'b1;
    end
    if (cmp_b_chg) begin
      next_flags[`BIT_CMP_B] = 1'b1;
    end
    if (cmp_a_chg) begin
      next_flags[`BIT_CMP_A] = 1'b1;
    end
    if (nv_chg && !nv_lvl) begin
      next_flags[`BIT_NV_DONE] = 1'b1;
    end
    next_flags = next_flags & `FLAGS2_IMPL;
  end

  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      flags <= `BYTE_ZERO;
      mask <= `BYTE_ZERO;
      latch <= `LATCH_RESET;
    end else begin
      flags <= next_flags;
      if (WR_I && ADDR_I == `ADDR_IRQ_MASK) begin
        mask <= WDATA_I & `FLAGS2_IMPL;
      end
      if (WR_I && ADDR_I == `ADDR_PCLATCH) begin
        latch <= WDATA_I[`LATCH_W-1:0];
      end
    end
  end

  // Power control; reset causes arrive as synchronous pulses
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wake_en <= 1'b0;
      sbor_en <= 1'b1;
      por_stat <= 1'b0;
      bor_stat <= 1'b0;
    end else if (POR_PULSE_I) begin
      wake_en <= 1'b0;
      sbor_en <= 1'b1;
      por_stat <= 1'b0;
      bor_stat <= 1'b0;
    end else begin
      if (wr_pwr) begin
        wake_en <= WDATA_I[`BIT_WAKE_EN];
        sbor_en <= WDATA_I[`BIT_SBOR_EN];
        por_stat <= WDATA_I[`BIT_POR_STAT];
        bor_stat <= WDATA_I[`BIT_BOR_STAT];
      end
      if (BOR_PULSE_I) begin
        bor_stat <= 1'b0;
      end
    end
  end

  assign pwr_view = {2'b00, wake_en, sbor_en, 2'b00, por_stat, bor_stat};
  assign WAKE_EN_O = wake_en;
  assign BOR_EN_O = sbor_en && (BOR_CFG_I == `BOR_CFG_SOFT);
  assign IRQ_O = |(flags & mask);

  // Read data one cycle after the strobe, zero otherwise
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RDATA_O <= `BYTE_ZERO;
    end else if (RD_I) begin
      case (ADDR_I)
        `ADDR_FLAGS2: RDATA_O <= flags;
        `ADDR_PWRCTL: RDATA_O <= pwr_view;
        `ADDR_PCLOW: RDATA_O <= PC_O[7:0];
        `ADDR_PCLATCH: RDATA_O <= {3'b000, latch};
        `ADDR_IRQ_MASK: RDATA_O <= mask;
        default: RDATA_O <= `BYTE_ZERO;
      endcase
    end else begin
      RDATA_O <= `BYTE_ZERO;
    end
  end
endmodule

// [src/core_flags_regs.vh]
// Register map, field positions and reset values of the core flag block.
// Assumes inclusion by bare name from the design files.
`ifndef CORE_FLAGS_REGS_VH
`define CORE_FLAGS_REGS_VH

`define ADDR_W 4
`define ADDR_FLAGS2 4'h0
`define ADDR_PWRCTL 4'h1
`define ADDR_PCLOW 4'h2
`define ADDR_PCLATCH 4'h3
`define ADDR_IRQ_MASK 4'h4
`define ADDR_PC_HIGH 4'h5

`define BIT_OSC_FAIL 7
`define BIT_CMP_B 6
`define BIT_CMP_A 5
`define BIT_NV_DONE 4
`define FLAGS2_IMPL 8'hF0

`define BIT_WAKE_EN 5
`define BIT_SBOR_EN 4
`define BIT_POR_STAT 1
`define BIT_BOR_STAT 0
`define PWRCTL_IMPL 8'h33

`define BOR_CFG_SOFT 2'h1
`define PC_W 13
`define LATCH_W 5
`define LATCH_RESET 5'h00
`define PC_RESET 13'h0000
`define GOTO_W 11
`define BYTE_ZERO 8'h00

`endif

// [src/edge_event.v]
// Three-stage synchroniser with agreement check and change detector.
// Assumes an asynchronous input and a single clock domain.
`timescale 1ns/1ns
`include "core_flags_regs.vh"
module edge_event (
  input wire clk_i,
  input wire rst_b_i,
  input wire async_i,
  output reg level_o,
  output wire change_o
);
  reg meta;
  reg s2;
  reg s3;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_o <= 1'b0;
    end else begin
      meta <= async_i;
      s2 <= meta;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end
  assign change_o = (s2 == s3) && (s3 != level_o);
endmodule

// [src/pc_unit.v]
// Program counter with high latch loading on low-byte writes and jumps.
// Assumes the core presents one load request per instruction cycle.
`timescale 1ns/1ns
`include "core_flags_regs.vh"
module pc_unit #(
  parameter PC_W = `PC_W
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire advance_i,
  input wire low_write_i,
  input wire [7:0] low_data_i,
  input wire jump_i,
  input wire [`GOTO_W-1:0] target_i,
  input wire [`LATCH_W-1:0] latch_i,
  output reg [PC_W-1:0] pc_o
);
  reg [PC_W-1:0] next_pc;
  always @* begin
    next_pc = pc_o;
    if (low_write_i) begin
      next_pc = {latch_i, low_data_i};
    end else if (jump_i) begin
      next_pc = {latch_i[4:3], target_i};
    end else if (advance_i) begin
      next_pc = pc_o + {{(PC_W-1){1'b0}}, 1'b1};
    end
  end
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc_o <= `PC_RESET;
    end else begin
      pc_o <= next_pc;
    end
  end
endmodule

// [verif/core_flags_checker.sv]
// Port-level assertions for the core flag block.
// Assumes one clock domain and a bind from the bench top file.
`timescale 1ns/1ns
`include "core_flags_regs.vh"
module core_flags_checker (
  input wire CLK_I, RST_B_I, POR_PULSE_I, BOR_PULSE_I, WR_I, RD_I, ADVANCE_I, JUMP_I,
  input wire WAKE_EN_O, BOR_EN_O,
  input wire [1:0] BOR_CFG_I,
  input wire [`ADDR_W-1:0] ADDR_I,
  input wire [7:0] WDATA_I, RDATA_O,
  input wire [`GOTO_W-1:0] TARGET_I,
  input wire [`PC_W-1:0] PC_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  wire pcl_wr = WR_I && ADDR_I == `ADDR_PCLOW;
  wire quiet = !POR_PULSE_I && !BOR_PULSE_I;
  a_bor_gate: assert property (BOR_EN_O |-> BOR_CFG_I == `BOR_CFG_SOFT)
    else $error("brownout enable without config");
  a_flag_pad: assert property ($past(RD_I) && $past(ADDR_I) == `ADDR_FLAGS2 |-> RDATA_O[3:0] == 4'h0)
    else $error("flag pad bits set");
  a_pwr_pad: assert property ($past(RD_I) && $past(ADDR_I) == `ADDR_PWRCTL |->
    RDATA_O[7:6] == 2'h0 && RDATA_O[3:2] == 2'h0)
    else $error("power pad bits set");
  a_pc_low: assert property (pcl_wr && quiet |=> PC_O[7:0] == $past(WDATA_I))
    else $error("pc low byte not loaded");
  a_pc_jump: assert property (JUMP_I && !pcl_wr && quiet |=> PC_O[10:0] == $past(TARGET_I))
    else $error("jump target not loaded");
  a_pc_step: assert property (ADVANCE_I && !JUMP_I && !pcl_wr && quiet |=>
    PC_O == $past(PC_O) + 13'h1)
    else $error("pc did not step");
  a_pc_hold: assert property (!ADVANCE_I && !JUMP_I && !pcl_wr && quiet |=> $stable(PC_O))
    else $error("pc moved while idle");
  a_wake_por: assert property (POR_PULSE_I |=> !WAKE_EN_O)
    else $error("wake enable kept over power-on");
endmodule

// [verif/core_flags_tb.sv]
// Self-checking bench for the core flag block.
// Assumes the design sources and the checker are compiled first.
`timescale 1ns/1ns
`include "core_flags_regs.vh"
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin err_total++; \
  $display("mismatch %s expected %h seen %h", n, e, a); end end
module core_flags_tb;
  reg CLK_I = 0, RST_B_I = 0, POR_PULSE_I = 0, BOR_PULSE_I = 0, OSC_FAIL_I = 0;
  reg CMP_A_I = 0, CMP_B_I = 0, NV_DONE_I = 0, WR_I = 0, RD_I = 0, ADVANCE_I = 0, JUMP_I = 0;
  reg [1:0] BOR_CFG_I = 2'h1;
  reg [`ADDR_W-1:0] ADDR_I = 4'h0;
  reg [7:0] WDATA_I = 8'h00;
  reg [`GOTO_W-1:0] TARGET_I = 11'h000;
  wire [7:0] RDATA_O;
  wire [`PC_W-1:0] PC_O;
  wire WAKE_EN_O, BOR_EN_O, IRQ_O;
  int err_total = 0;
  int check_count = 0;
  core_flags i_core_flags (.CLK_I, .RST_B_I, .POR_PULSE_I, .BOR_PULSE_I, .BOR_CFG_I,
    .OSC_FAIL_I, .CMP_A_I, .CMP_B_I, .NV_DONE_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
    .RDATA_O, .ADVANCE_I, .JUMP_I, .TARGET_I, .PC_O, .WAKE_EN_O, .BOR_EN_O, .IRQ_O);
  always #5 CLK_I = ~CLK_I;
  task wr(input [3:0] a, input [7:0] d);
    @(posedge CLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'h1;
    @(posedge CLK_I);
    WR_I <= 1'h0;
    #1;
  endtask
  task rd(input [3:0] a, input [7:0] e);
    @(posedge CLK_I);
    ADDR_I <= a;
    RD_I <= 1'h1;
    @(posedge CLK_I);
    RD_I <= 1'h0;
    #1 `CHK("rdata", e, RDATA_O)
  endtask
  task t_reset;
    `CHK("pc", `PC_RESET, PC_O)
    rd(`ADDR_FLAGS2, 8'h00);
    rd(`ADDR_PWRCTL, 8'h10);
    `CHK("bor_en", 1'h1, BOR_EN_O)
    $display("test reset done");
  endtask
  task t_flags;
    @(posedge CLK_I);
    {OSC_FAIL_I, CMP_A_I, CMP_B_I, NV_DONE_I} <= 4'hF;
    repeat (8) @(posedge CLK_I);
    rd(`ADDR_FLAGS2, 8'hF0);
    `CHK("irq", 1'h0, IRQ_O)
    wr(`ADDR_FLAGS2, 8'h00);
    rd(`ADDR_FLAGS2, 8'h00);
    wr(`ADDR_IRQ_MASK, 8'h20);
    `CHK("irq", 1'h0, IRQ_O)
    @(posedge CLK_I);
    CMP_A_I <= 1'h0;
    repeat (8) @(posedge CLK_I);
    rd(`ADDR_FLAGS2, 8'h20);
    `CHK("irq", 1'h1, IRQ_O)
    @(posedge CLK_I);
    CMP_B_I <= 1'h0;
    repeat (8) @(posedge CLK_I);
    rd(`ADDR_FLAGS2, 8'h60);
    $display("test flags done");
  endtask
  task t_pwr;
    wr(`ADDR_PWRCTL, 8'hFF);
    rd(`ADDR_PWRCTL, 8'h33);
    `CHK("wake", 1'h1, WAKE_EN_O)
    BOR_CFG_I <= 2'h2;
    #1 `CHK("bor_en", 1'h0, BOR_EN_O)
    @(posedge CLK_I);
    BOR_PULSE_I <= 1'h1;
    BOR_CFG_I <= 2'h1;
    @(posedge CLK_I);
    BOR_PULSE_I <= 1'h0;
    rd(`ADDR_PWRCTL, 8'h32);
    wr(`ADDR_PWRCTL, 8'h33);
    rd(`ADDR_PWRCTL, 8'h33);
    @(posedge CLK_I);
    POR_PULSE_I <= 1'h1;
    @(posedge CLK_I);
    POR_PULSE_I <= 1'h0;
    rd(`ADDR_PWRCTL, 8'h10);
    $display("test power done");
  endtask
  task t_pc;
    wr(`ADDR_PCLATCH, 8'h1F);
    wr(`ADDR_PCLOW, 8'hA5);
    `CHK("pc", 13'h1FA5, PC_O)
    TARGET_I <= 11'h123;
    JUMP_I <= 1'h1;
    @(posedge CLK_I);
    JUMP_I <= 1'h0;
    ADVANCE_I <= 1'h1;
    #1 `CHK("pc", 13'h1923, PC_O)
    @(posedge CLK_I);
    ADVANCE_I <= 1'h0;
    #1 `CHK("pc", 13'h1924, PC_O)
    RST_B_I <= 1'h0;
    #1 `CHK("pc", `PC_RESET, PC_O)
    @(posedge CLK_I);
    RST_B_I <= 1'h1;
    $display("test pc done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge CLK_I);
    RST_B_I <= 1'h1;
    t_reset;
    t_flags;
    t_pwr;
    t_pc;
    wrap_up;
  end
  initial begin
    #100000;
    err_total++;
    wrap_up;
  end
endmodule
bind core_flags core_flags_checker i_core_flags_checker (.CLK_I, .RST_B_I, .POR_PULSE_I,
  .BOR_PULSE_I, .WR_I, .RD_I, .ADVANCE_I, .JUMP_I, .WAKE_EN_O, .BOR_EN_O, .BOR_CFG_I,
  .ADDR_I, .WDATA_I, .RDATA_O, .TARGET_I, .PC_O);
